//--- rtl/ucf_pkg.sv
// Shared constants, types and helpers of the character-format block
package ucf_pkg;

	// Register addresses on the three-bit register address lines
	localparam logic [2:0] ADDR_DATA   = 3'h0;
	localparam logic [2:0] ADDR_IER    = 3'h1;
	localparam logic [2:0] ADDR_LFC    = 3'h3;
	localparam logic [2:0] ADDR_STATUS = 3'h5;

	// Values after reset
	localparam logic [7:0]  LFC_RESET = 8'h00;
	localparam logic [7:0]  DIV_RESET_LO = 8'h01;
	localparam logic [7:0]  DIV_RESET_HI = 8'h00;
	localparam logic [4:0]  IER_RESET = 5'h00;

	// Oversampling and stop lengths in baud ticks
	localparam int unsigned OVERSAMPLE = 16;
	localparam int unsigned HALF_BIT   = OVERSAMPLE / 2;
	localparam int unsigned STOP_ONE   = OVERSAMPLE;
	localparam int unsigned STOP_ONE_HALF = OVERSAMPLE + HALF_BIT;
	localparam int unsigned STOP_TWO   = 2 * OVERSAMPLE;
	localparam int unsigned MIN_BITS   = 5;

	// Character length codes
	localparam logic [1:0] LEN_FIVE = 2'h0;

	// Line format control layout, bit 7 down to bit 0
	typedef struct packed {
		logic       divLatchSel;
		logic       setBreak;
		logic       stickPar;
		logic       evenPar;
		logic       parEn;
		logic       stopCount;
		logic [1:0] charLen;
	} ucf_lfc_t;

	// One host access on the register pins
	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [2:0] addr;
		logic [7:0] data;
	} ucf_req_t;

	// Receive status flags
	typedef struct packed {
		logic framingErr;
		logic parityErr;
		logic overrun;
		logic dataReady;
	} ucf_rxstat_t;

	// Data bits per character
	function automatic logic [3:0] ucf_nbits(input ucf_lfc_t cfg);
		return 4'(MIN_BITS) + {2'h0, cfg.charLen};
	endfunction

	// Parity bit for a character of the configured length
	function automatic logic ucf_par(input ucf_lfc_t cfg, input logic [7:0] data);
		logic [7:0] masked;
		masked = data & 8'(({8'h00, 8'hff} >> (4'd8 - ucf_nbits(cfg))));
		if (cfg.stickPar)
			return !cfg.evenPar;
		return cfg.evenPar ? ^masked : ~^masked;
	endfunction

	// Stop length in ticks
	function automatic logic [5:0] ucf_stop_ticks(input ucf_lfc_t cfg);
		if (!cfg.stopCount)
			return 6'(STOP_ONE);
		if (cfg.charLen == LEN_FIVE)
			return 6'(STOP_ONE_HALF);
		return 6'(STOP_TWO);
	endfunction

endpackage

//--- rtl/ucf_line_format.sv
// Asynchronous character framing with line format control register
`timescale 1ns/10ps
module ucf_line_format #(
	parameter int unsigned BUF_DEPTH = 2
) (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       nrst,
	// Register pins
	input  wire logic [2:0] registerAddressLines,
	input  wire logic       chipSel,
	input  wire logic       rdStrobe,
	input  wire logic       wrStrobe,
	input  wire logic [7:0] wrData,
	output logic      [7:0] rdData,
	// Serial line
	input  wire logic       rxPin,
	output logic            txPin,
	// Status
	output logic            txHoldReady,
	output logic            rxDataReady
);

	if (BUF_DEPTH < 2 || (BUF_DEPTH & (BUF_DEPTH - 1)) != 0)
	begin : g_depthCheck
		$error("BUF_DEPTH must be a power of two, at least 2");
	end

	localparam int PW = $clog2(BUF_DEPTH);

	typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_PAR, ST_STOP} ucf_state_t;

	ucf_pkg::ucf_req_t    req;
	ucf_pkg::ucf_lfc_t    lfc_q, lfc_d;
	ucf_pkg::ucf_rxstat_t stat_q, stat_d;
	logic [7:0]           dll_q, dll_d, dlm_q, dlm_d, rbr_q, rbr_d, rdData_q, rdData_d;
	logic [4:0]           ier_q, ier_d;
	logic                 everWrote_q;
	logic                 push, pop, bufValid, dataSel;
	logic [7:0]           bufMem [BUF_DEPTH];
	logic [PW-1:0]        wrPtr_q, rdPtr_q;
	logic [PW:0]          count_q, count_d;
	logic [15:0]          baudCnt_q, baudCnt_d;
	logic                 tick;
	logic                 rxMeta_q, rxIn_q;

	assign req = '{rd: chipSel & rdStrobe, wr: chipSel & wrStrobe,
		addr: registerAddressLines, data: wrData};
	assign dataSel = !lfc_q.divLatchSel;

	// Register file
	always_comb
	begin
		lfc_d = lfc_q;
		dll_d = dll_q;
		dlm_d = dlm_q;
		ier_d = ier_q;
		rdData_d = rdData_q;
		push = 1'b0;
		if (req.wr)
		begin
			case (req.addr)
				ucf_pkg::ADDR_DATA: if (dataSel) push = 1'b1; else dll_d = req.data;
				ucf_pkg::ADDR_IER:  if (dataSel) ier_d = req.data[4:0]; else dlm_d = req.data;
				ucf_pkg::ADDR_LFC:  lfc_d = ucf_pkg::ucf_lfc_t'(req.data);
				default: ;
			endcase
		end
		if (req.rd)
		begin
			case (req.addr)
				ucf_pkg::ADDR_DATA:   rdData_d = dataSel ? rbr_q : dll_q;
				ucf_pkg::ADDR_IER:    rdData_d = dataSel ? {3'h0, ier_q} : dlm_q;
				ucf_pkg::ADDR_LFC:    rdData_d = lfc_q;
				ucf_pkg::ADDR_STATUS: rdData_d = {2'h0, txHoldReady, 1'b0, stat_q};
				default:              rdData_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			lfc_q <= ucf_pkg::LFC_RESET;
			dll_q <= ucf_pkg::DIV_RESET_LO;
			dlm_q <= ucf_pkg::DIV_RESET_HI;
			ier_q <= ucf_pkg::IER_RESET;
			rdData_q <= 8'h00;
			everWrote_q <= 1'b0;
		end
		else
		begin
			lfc_q <= lfc_d;
			dll_q <= dll_d;
			dlm_q <= dlm_d;
			ier_q <= ier_d;
			rdData_q <= rdData_d;
			everWrote_q <= everWrote_q | (req.wr && req.addr == ucf_pkg::ADDR_LFC);
		end
	end

	assign rdData = rdData_q;

	// BUF_DEPTH-entry transmit buffer, two entries by default
	assign txHoldReady = count_q != (PW + 1)'(BUF_DEPTH);
	assign bufValid = count_q != '0;
	always_comb
	begin
		count_d = count_q;
		if (push && txHoldReady && !pop)
			count_d = count_q + 1'b1;
		else if (pop && !(push && txHoldReady))
			count_d = count_q - 1'b1;
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
		end
		else
		begin
			wrPtr_q <= wrPtr_q + PW'(push && txHoldReady);
			rdPtr_q <= rdPtr_q + PW'(pop);
			count_q <= count_d;
		end
	end

	always_ff @(posedge clk)
	begin
		if (push && txHoldReady)
			bufMem[wrPtr_q] <= req.data;
	end

	// Baud tick at sixteen times the bit rate
	always_comb
	begin
		tick = ({dlm_q, dll_q} <= 16'h0001) || (baudCnt_q == {dlm_q, dll_q} - 16'h0001);
		baudCnt_d = tick ? 16'h0000 : baudCnt_q + 16'h0001;
	end

	// Transmitter
	ucf_state_t        txState_q, txState_d;
	ucf_pkg::ucf_lfc_t txCfg_q, txCfg_d;
	logic [7:0]        txShift_q, txShift_d, txData_q, txData_d;
	logic [2:0]        txBit_q, txBit_d;
	logic [5:0]        txTick_q, txTick_d, txSpan;
	logic              txEnd, txLine_q, txLine_d;

	always_comb
	begin
		txState_d = txState_q;
		txCfg_d = txCfg_q;
		txShift_d = txShift_q;
		txData_d = txData_q;
		txBit_d = txBit_q;
		txTick_d = txTick_q;
		pop = 1'b0;
		txSpan = (txState_q == ST_STOP) ? ucf_pkg::ucf_stop_ticks(txCfg_q)
			: 6'(ucf_pkg::OVERSAMPLE);
		txEnd = tick && (txTick_q == txSpan - 6'h01);
		if (tick)
			txTick_d = txEnd ? 6'h00 : txTick_q + 6'h01;
		case (txState_q)
			ST_IDLE:
			begin
				txTick_d = 6'h00;
				if (bufValid)
				begin
					pop = 1'b1;
					txState_d = ST_START;
					txCfg_d = lfc_q;
					txShift_d = bufMem[rdPtr_q];
					txData_d = bufMem[rdPtr_q];
				end
			end
			ST_START: if (txEnd) begin txState_d = ST_DATA; txBit_d = 3'h0; end
			ST_DATA:
			begin
				if (txEnd)
				begin
					txShift_d = {1'b0, txShift_q[7:1]};
					txBit_d = txBit_q + 3'h1;
					if ({1'b0, txBit_q} == ucf_pkg::ucf_nbits(txCfg_q) - 4'h1)
						txState_d = txCfg_q.parEn ? ST_PAR : ST_STOP;
				end
			end
			ST_PAR: if (txEnd) txState_d = ST_STOP;
			ST_STOP: if (txEnd) txState_d = ST_IDLE;
			default: txState_d = ST_IDLE;
		endcase
		case (txState_d)
			ST_START: txLine_d = 1'b0;
			ST_DATA:  txLine_d = txShift_d[0];
			ST_PAR:   txLine_d = ucf_pkg::ucf_par(txCfg_d, txData_d);
			default:  txLine_d = 1'b1;
		endcase
		if (lfc_q.setBreak)
			txLine_d = 1'b0;
	end

	// Receiver
	ucf_state_t        rxState_q, rxState_d;
	ucf_pkg::ucf_lfc_t rxCfg_q, rxCfg_d;
	logic [7:0]        rxShift_q, rxShift_d, rxAligned;
	logic [2:0]        rxBit_q, rxBit_d;
	logic [5:0]        rxTick_q, rxTick_d;
	logic              rxEnd, rxParBad_q, rxParBad_d, rdRbr, rdStat;

	always_comb
	begin
		rxState_d = rxState_q;
		rxCfg_d = rxCfg_q;
		rxShift_d = rxShift_q;
		rxBit_d = rxBit_q;
		rxParBad_d = rxParBad_q;
		rbr_d = rbr_q;
		rdRbr = req.rd && req.addr == ucf_pkg::ADDR_DATA && dataSel;
		rdStat = req.rd && req.addr == ucf_pkg::ADDR_STATUS;
		stat_d = stat_q;
		if (rdRbr)
			stat_d.dataReady = 1'b0;
		if (rdStat)
			stat_d = '{framingErr: 1'b0, parityErr: 1'b0, overrun: 1'b0,
				dataReady: stat_d.dataReady};
		rxAligned = rxShift_q >> (4'd8 - ucf_pkg::ucf_nbits(rxCfg_q));
		rxEnd = tick && (rxTick_q == ((rxState_q == ST_START)
			? 6'(ucf_pkg::HALF_BIT - 1) : 6'(ucf_pkg::OVERSAMPLE - 1)));
		rxTick_d = !tick ? rxTick_q : (rxEnd ? 6'h00 : rxTick_q + 6'h01);
		case (rxState_q)
			ST_IDLE:
			begin
				rxTick_d = 6'h00;
				if (!rxIn_q)
				begin
					rxState_d = ST_START;
					rxCfg_d = lfc_q;
					rxParBad_d = 1'b0;
				end
			end
			ST_START: if (rxEnd) begin rxState_d = rxIn_q ? ST_IDLE : ST_DATA; rxBit_d = 3'h0; end
			ST_DATA:
			begin
				if (rxEnd)
				begin
					rxShift_d = {rxIn_q, rxShift_q[7:1]};
					rxBit_d = rxBit_q + 3'h1;
					if ({1'b0, rxBit_q} == ucf_pkg::ucf_nbits(rxCfg_q) - 4'h1)
						rxState_d = rxCfg_q.parEn ? ST_PAR : ST_STOP;
				end
			end
			ST_PAR:
			begin
				if (rxEnd)
				begin
					rxParBad_d = rxIn_q != ucf_pkg::ucf_par(rxCfg_q, rxAligned);
					rxState_d = ST_STOP;
				end
			end
			ST_STOP:
			begin
				if (rxEnd)
				begin
					rxState_d = ST_IDLE;
					rbr_d = rxAligned;
					stat_d.overrun = stat_d.overrun | (stat_q.dataReady & !rdRbr);
					stat_d.dataReady = 1'b1;
					stat_d.parityErr = stat_d.parityErr | rxParBad_q;
					stat_d.framingErr = stat_d.framingErr | !rxIn_q;
				end
			end
			default: rxState_d = ST_IDLE;
		endcase
	end

	assign rxDataReady = stat_q.dataReady;
	assign txPin = txLine_q;

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			baudCnt_q <= 16'h0000;
			txState_q <= ST_IDLE;
			txCfg_q <= ucf_pkg::LFC_RESET;
			txShift_q <= 8'h00;
			txData_q <= 8'h00;
			txBit_q <= 3'h0;
			txTick_q <= 6'h00;
			txLine_q <= 1'b1;
			rxMeta_q <= 1'b1;
			rxIn_q <= 1'b1;
			rxState_q <= ST_IDLE;
			rxCfg_q <= ucf_pkg::LFC_RESET;
			rxShift_q <= 8'h00;
			rxBit_q <= 3'h0;
			rxTick_q <= 6'h00;
			rxParBad_q <= 1'b0;
			rbr_q <= 8'h00;
			stat_q <= '0;
		end
		else
		begin
			baudCnt_q <= baudCnt_d;
			txState_q <= txState_d;
			txCfg_q <= txCfg_d;
			txShift_q <= txShift_d;
			txData_q <= txData_d;
			txBit_q <= txBit_d;
			txTick_q <= txTick_d;
			txLine_q <= txLine_d;
			rxMeta_q <= rxPin;
			rxIn_q <= rxMeta_q;
			rxState_q <= rxState_d;
			rxCfg_q <= rxCfg_d;
			rxShift_q <= rxShift_d;
			rxBit_q <= rxBit_d;
			rxTick_q <= rxTick_d;
			rxParBad_q <= rxParBad_d;
			rbr_q <= rbr_d;
			stat_q <= stat_d;
		end
	end

	// Checks
	a_char_length: assert property (@(posedge clk) disable iff (!nrst)
		(txState_q == ST_DATA && txState_d != ST_DATA)
		|-> {1'b0, txBit_q} == 4'(ucf_pkg::MIN_BITS - 1) + {2'h0, txCfg_q.charLen})
		else $error("character length wrong");
	a_stop_one: assert property (@(posedge clk) disable iff (!nrst)
		(txState_q == ST_STOP && txEnd && !txCfg_q.stopCount) |-> txTick_q == 6'd15)
		else $error("one stop bit length wrong");
	a_stop_onehalf: assert property (@(posedge clk) disable iff (!nrst)
		(txState_q == ST_STOP && txEnd && txCfg_q.stopCount && txCfg_q.charLen == 2'h0)
		|-> txTick_q == 6'd23)
		else $error("one and half stop length wrong");
	a_stop_two: assert property (@(posedge clk) disable iff (!nrst)
		(txState_q == ST_STOP && txEnd && txCfg_q.stopCount && txCfg_q.charLen != 2'h0)
		|-> txTick_q == 6'd31)
		else $error("two stop length wrong");
	a_rx_first_stop: assert property (@(posedge clk) disable iff (!nrst)
		(rxState_q == ST_STOP && rxEnd) |=> rxState_q == ST_IDLE && stat_q.dataReady)
		else $error("receiver did not end on first stop");
	a_par_position: assert property (@(posedge clk) disable iff (!nrst)
		(txState_q == ST_DATA && txState_d != ST_DATA) |=> (txState_q == ST_PAR) == txCfg_q.parEn)
		else $error("parity slot misplaced");
	a_par_value: assert property (@(posedge clk) disable iff (!nrst)
		(txState_q == ST_PAR && !$past(lfc_q.setBreak) && !txCfg_q.stickPar)
		|-> (^(txData_q & 8'(({8'h00, 8'hff} >> (4'd8 - ucf_pkg::ucf_nbits(txCfg_q)))))
			^ txLine_q) == !txCfg_q.evenPar)
		else $error("parity sense wrong");
	a_lfc_readback: assert property (@(posedge clk) disable iff (!nrst)
		(req.wr && req.addr == 3'h3) ##1 !(req.wr && req.addr == 3'h3)
		##1 (req.rd && !req.wr && req.addr == 3'h3) |=> rdData == $past(wrData, 3))
		else $error("format readback mismatch");
	a_stick_par: assert property (@(posedge clk) disable iff (!nrst)
		(txState_q == ST_PAR && !$past(lfc_q.setBreak) && txCfg_q.stickPar)
		|-> txLine_q == !txCfg_q.evenPar)
		else $error("stick parity wrong");
	a_div_select: assert property (@(posedge clk) disable iff (!nrst)
		(req.wr && req.addr == 3'h0 && lfc_q.divLatchSel) |=> dll_q == $past(wrData) && $stable(wrPtr_q))
		else $error("divisor latch not written");
	a_lsb_first: assert property (@(posedge clk) disable iff (!nrst)
		(txState_q == ST_DATA && txBit_q == 3'h0 && !$past(lfc_q.setBreak))
		|-> txLine_q == txData_q[0])
		else $error("first data bit not lsb");
	a_reset_format: assert property (@(posedge clk) disable iff (!nrst)
		!everWrote_q |-> lfc_q == 8'h00)
		else $error("format not zero after reset");

	c_stop_onehalf: cover property (@(posedge clk) disable iff (!nrst)
		txState_q == ST_STOP && txEnd && txCfg_q.stopCount && txCfg_q.charLen == 2'h0);
	c_parity_err: cover property (@(posedge clk) disable iff (!nrst) $rose(stat_q.parityErr));
	c_rx_char: cover property (@(posedge clk) disable iff (!nrst) $rose(stat_q.dataReady));
	c_buf_full: cover property (@(posedge clk) disable iff (!nrst) !txHoldReady);

endmodule // ucf_line_format

//--- verif/ucf_line_model.sv
// Serial line partner: captures transmitted frames and drives received ones
`timescale 1ns/10ps
module ucf_line_model (
	// Clock
	input  wire logic clk,
	// Serial line
	input  wire logic txPin,
	output logic      rxPin
);
	initial rxPin = 1'b1;

	// Capture one frame; len is start to next start in clocks, 0 if idle after
	task automatic grab(input int nb, output logic [8:0] bits, output logic [15:0] len);
		int   k;
		logic hi;
		bits = '0;
		k = 0;
		hi = 1'b0;
		while (txPin !== 1'b0 && k < 4000)
		begin
			@(posedge clk);
			k++;
		end
		repeat (8) @(posedge clk);
		for (int b = 0; b < nb; b++)
		begin
			repeat (16) @(posedge clk);
			bits[b] = txPin;
		end
		k = 0;
		do
		begin
			@(posedge clk);
			k++;
			hi = hi | (txPin === 1'b1);
		end
		while (!(hi && txPin === 1'b0) && k < 300);
		len = (k < 300) ? 16'(8 + 16 * nb + k) : 16'h0000;
	endtask

	// Drive nb bits, 16 clocks each, then idle high
	task automatic drive(input logic [15:0] bits, input int nb);
		for (int b = 0; b < nb; b++)
		begin
			rxPin <= bits[b];
			repeat (16) @(posedge clk);
		end
		rxPin <= 1'b1;
	endtask
endmodule // ucf_line_model

//--- verif/tb.sv
// Self-checking bench of the character-format block
`timescale 1ns/10ps
module tb;
	logic        clk;
	logic        nrst;
	logic [2:0]  addr;
	logic        chipSel;
	logic        rdStrobe;
	logic        wrStrobe;
	logic [7:0]  wrData;
	logic [7:0]  rdData;
	logic        rxPin;
	logic        txPin;
	logic        txHoldReady;
	logic        rxDataReady;
	int          miscompares = 0;
	int          cmp_count = 0;
	logic [7:0]  c;
	logic [7:0]  s;
	logic [7:0]  d [3];
	logic [8:0]  bits [3];
	logic [15:0] len [3];
	logic [15:0] f;
	int          n;
	int          nb;
	logic [7:0]  rxc [4] = '{8'h1b, 8'h0a, 8'h3b, 8'h04};
	logic [7:0]  rxs [4] = '{8'h01, 8'h05, 8'h09, 8'h03};

	ucf_line_format dut (
		.clk(clk), .nrst(nrst), .registerAddressLines(addr), .chipSel(chipSel),
		.rdStrobe(rdStrobe), .wrStrobe(wrStrobe), .wrData(wrData), .rdData(rdData),
		.rxPin(rxPin), .txPin(txPin), .txHoldReady(txHoldReady), .rxDataReady(rxDataReady)
	);
	ucf_line_model peer (.clk(clk), .txPin(txPin), .rxPin(rxPin));

	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	function automatic logic [7:0] msk(input logic [7:0] cf);
		return 8'hff >> (3 - int'(cf[1:0]));
	endfunction

	function automatic logic epar(input logic [7:0] cf, input logic [7:0] dv);
		if (cf[5])
			return !cf[4];
		return cf[4] ? ^(dv & msk(cf)) : ~^(dv & msk(cf));
	endfunction

	function automatic void mk(input logic [7:0] cf, input logic [7:0] dv, input logic bp,
		input logic bs, inout logic [15:0] fr, inout int k);
		fr[k] = 1'b0;
		for (int b = 0; b < 5 + int'(cf[1:0]); b++)
			fr[k + 1 + b] = dv[b];
		k = k + 6 + int'(cf[1:0]);
		if (cf[3])
		begin
			fr[k] = epar(cf, dv) ^ bp;
			k++;
		end
		fr[k] = !bs;
		k++;
	endfunction

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] v);
		chipSel  <= 1'b1;
		wrStrobe <= 1'b1;
		addr     <= a;
		wrData   <= v;
		@(posedge clk);
		chipSel  <= 1'b0;
		wrStrobe <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rd(input logic [2:0] a, output logic [7:0] v);
		chipSel  <= 1'b1;
		rdStrobe <= 1'b1;
		addr     <= a;
		@(posedge clk);
		chipSel  <= 1'b0;
		rdStrobe <= 1'b0;
		@(posedge clk);
		v = rdData;
	endtask

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial
	begin
		repeat (60000) @(posedge clk);
		miscompares++;
		complete_run();
	end

	initial
	begin
		nrst = 1'b0;
		addr = 3'h0;
		chipSel = 1'b0;
		rdStrobe = 1'b0;
		wrStrobe = 1'b0;
		wrData = 8'h00;
		void'($urandom(32'hfea96517));
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		chk({15'h0, txPin}, 16'h0001);
		chk({15'h0, rxDataReady}, 16'h0000);
		rd(ucf_pkg::ADDR_LFC, s);
		chk(s, 16'h0000);
		for (int i = 0; i < 6; i++)
		begin
			c = 8'($urandom) & 8'hbf;
			wr(ucf_pkg::ADDR_LFC, c);
			rd(ucf_pkg::ADDR_LFC, s);
			chk(s, c);
		end
		wr(ucf_pkg::ADDR_LFC, 8'h80);
		rd(3'h0, s);
		chk(s, 16'h0001);
		wr(3'h0, 8'h03);
		rd(3'h0, s);
		chk(s, 16'h0003);
		wr(3'h0, 8'h01);
		c = 8'($urandom);
		wr(3'h1, c);
		rd(3'h1, s);
		chk(s, c);
		wr(3'h1, 8'h00);
		wr(ucf_pkg::ADDR_LFC, 8'h40);
		@(posedge clk);
		chk({15'h0, txPin}, 16'h0000);
		wr(ucf_pkg::ADDR_LFC, 8'h00);
		@(posedge clk);
		chk({15'h0, txPin}, 16'h0001);
		rd(3'h2, s);
		chk(s, 16'h0000);
		$display("test registers done");
		for (int i = 0; i < 8; i++)
		begin
			c = {2'b00, i[1] ^ i[2], i[0] ^ i[2], i != 3, i[2], i[1:0]};
			nb = 5 + i % 4 + int'(c[3]);
			for (int j = 0; j < 3; j++)
				d[j] = 8'($urandom);
			wr(ucf_pkg::ADDR_LFC, c);
			fork
				for (int j = 0; j < 3; j++)
					peer.grab(nb, bits[j], len[j]);
				begin
					for (int j = 0; j < 4; j++)
						wr(3'h0, j < 3 ? d[j] : 8'h5a);
					chk({15'h0, txHoldReady}, 16'h0000);
				end
			join
			for (int j = 0; j < 3; j++)
			begin
				chk(16'(bits[j]) & 16'(msk(c)), d[j] & msk(c));
				if (c[3])
					chk(bits[j][nb - 1], epar(c, d[j]));
			end
			// One idle clock between back-to-back characters
			f = 16'(17 + 16 * nb) + (!c[2] ? 16'd16 : i % 4 == 0 ? 16'd24 : 16'd32);
			for (int j = 0; j < 2; j++)
				chk(len[j], f);
			chk(len[2], 16'h0000);
			chk({15'h0, txHoldReady}, 16'h0001);
		end
		$display("test transmit done");
		for (int i = 0; i < 4; i++)
		begin
			c = rxc[i];
			d[0] = 8'($urandom);
			f = '1;
			n = 0;
			mk(c, d[0], i == 1, i == 2, f, n);
			if (i == 3)
			begin
				d[0] = 8'($urandom);
				mk(c, d[0], 1'b0, 1'b0, f, n);
			end
			wr(ucf_pkg::ADDR_LFC, c);
			peer.drive(f, n);
			for (int k = 0; k < 40 && rxDataReady !== 1'b1; k++)
				@(posedge clk);
			chk({15'h0, rxDataReady}, 16'h0001);
			rd(ucf_pkg::ADDR_STATUS, s);
			chk(s & 8'h0f, rxs[i]);
			rd(3'h0, s);
			chk(s, d[0] & msk(c));
		end
		$display("test receive done");
		complete_run();
	end
endmodule // tb
